//--- sleep_ctrl_consts.vh
// Purpose: Constants for the sleep and MCU control register bank
// Assumes: 8-bit CPU register port, byte addresses in data space
// Notes:   Port-instruction addresses are data addresses minus 0x20
`ifndef SLEEP_CTRL_CONSTS_VH
`define SLEEP_CTRL_CONSTS_VH

// ----------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------
`define SLP_CTRL_ADDR      8'h53
`define MCU_CTRL_ADDR      8'h55
`define IO_ADDR_OFFSET     8'h20

// ----------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------
`define SLP_CTRL_RESET     8'h00
`define MCU_CTRL_RESET     8'h00
`define SLP_ALLOW_BIT      0
`define SLP_SEL_LSB        1
`define SLP_SEL_MSB        3
`define SCAN_DIS_BIT       7
`define BOD_OFF_BIT        6
`define BOD_UNLOCK_BIT     5
`define PULLUP_KILL_BIT    4
`define VEC_SEL_BIT        1
`define VEC_UNLOCK_BIT     0
`define MCU_CTRL_MASK      8'hF3
`define SLP_CTRL_MASK      8'h0F

// ----------------------------------------------------------------
// Sleep mode codes
// ----------------------------------------------------------------
`define MODE_IDLE          3'h0
`define MODE_ADC_NR        3'h1
`define MODE_PWR_DOWN      3'h2
`define MODE_PWR_SAVE      3'h3
`define MODE_STANDBY       3'h6
`define MODE_EXT_STANDBY   3'h7

// ----------------------------------------------------------------
// Timing in clock cycles
// ----------------------------------------------------------------
`define UNLOCK_CYCLES      3'h4
`define BOD_DELAY_CYCLES   3'h3
`define BOD_HOLD_CYCLES    3'h3
`define STBY_WAKE_CYCLES   3'h6

`endif

//--- unlock_timer.v
// Purpose: Down-counter window for a timed unlock sequence
// Assumes: start pulse from a qualifying write
// Notes:   Restart while open reloads the window
`timescale 1ns/1ps

module unlock_timer #(
    parameter [2:0] WINDOW = 3'h4
) (
    input  wire clk,
    input  wire nrst,
    input  wire start,
    input  wire cancel,
    output wire open
);

    reg [2:0] count_r;
    reg [2:0] count_nxt;

    assign open = (count_r != 3'h0);

    always @* begin
        count_nxt = count_r;
        if (start) begin
            count_nxt = WINDOW;
        end else if (cancel) begin
            count_nxt = 3'h0;
        end else if (count_r != 3'h0) begin
            count_nxt = count_r - 3'h1;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_r <= 3'h0;
        end else begin
            count_r <= count_nxt;
        end
    end

endmodule

//--- sleep_and_mcu_control_regs.v
// Purpose: Sleep mode control and MCU control registers with timed
//          unlock sequences, plus sleep-time power steering outputs
// Assumes: CPU register port, one access per cycle, sleep_instr is a
//          one-cycle pulse from the decoder
// Notes:   Reset state is all zeros
//
// Contract
// - Three-bit field selects idle, ADC NR, down, save, -, -, standby, ext.
// - Sleep instruction sleeps only while sleep-allow is one.
// - Scan-port disable zero plus fuse enables scan port; one disables.
// - Scan-port disable changes only on two equal writes within four cycles.
// - Brownout-off set needs both-bits write then off-only write in four.
// - Brownout-off active three cycles after set, cleared three later.
// - Detector off only if sleep executes while brownout-off is active.
// - Pull-up kill disables all port pull-ups regardless of pin bits.
// - Vector select zero puts vectors at flash start, one at boot section.
// - Vector select changes only by unlock write then select write in four.
// - Interrupts blocked from unlock until after next instruction or four.
// - Automatic blocking leaves global interrupt enable flag untouched.
// - Hardware clears vector unlock after four cycles or on select write.
// - Boot lock bits disable interrupts in protected section by vector side.
// - Enabled ADC stays on in sleep; re-enable gives extended conversion.
// - Comparator off in deep sleep; vref kept if comparator uses it.
// - Input buffers off when I/O and ADC clocks stop, except wake pins.
// - Debug fuse keeps main clock in sleep; scan disable kills debug.
// - Enabled watchdog and fused brown-out detector stay on in sleep.
// - Reference on when detector, comparator or ADC needs it.
// - Registers at data 0x53 and 0x55; port access 0x20 lower.
// - Detector re-enabled automatically on wake-up.
// - Standby modes wake within six clock cycles.
`timescale 1ns/1ps
`include "sleep_ctrl_consts.vh"

module sleep_and_mcu_control_regs (
    input  wire       clk,
    input  wire       nrst,
    input  wire [7:0] addr,
    input  wire       io_space,
    input  wire       wr_en,
    input  wire       rd_en,
    input  wire [7:0] wdata,
    output reg  [7:0] rdata,
    input  wire       sleep_instr,
    input  wire       instr_done,
    input  wire       wake_event,
    input  wire       in_boot_section,
    input  wire       scan_fuse_enable,
    input  wire       debug_fuse_enable,
    input  wire       app_boot_lock_bit,
    input  wire       boot_boot_lock_bit,
    input  wire       brownout_fuse_en,
    input  wire       watchdog_en,
    input  wire       adc_en,
    input  wire       comparator_en,
    input  wire       comparator_uses_ref,
    input  wire       wake_pin_needed,
    output wire [2:0] sleep_mode,
    output reg        sleeping,
    output wire       scan_port_enable,
    output wire       pullup_kill,
    output wire       vector_table_select,
    output wire       irq_block,
    output wire       brownout_enable,
    output wire       adc_keep_on,
    output reg        adc_extended_conv,
    output wire       comparator_enable,
    output wire       vref_enable,
    output wire       input_buffer_enable,
    output wire       main_clock_keep,
    output wire       watchdog_keep,
    output reg        wake_ready
);

    // ----------------------------------------------------------------
    // Sleep states
    // ----------------------------------------------------------------
    localparam [1:0] ST_RUN   = 2'h0;
    localparam [1:0] ST_SLEEP = 2'h1;
    localparam [1:0] ST_WAKE  = 2'h2;

    reg [7:0] slp_r;
    reg [7:0] slp_nxt;
    reg       scan_dis_r;
    reg       bod_off_r;
    reg       pullup_kill_r;
    reg       vec_sel_r;
    reg       bod_unlock_r;
    reg       scan_pend_r;
    reg       scan_val_r;
    reg [2:0] bod_age_r;
    reg       bod_sw_off_r;
    reg       blk_tail_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [2:0] wake_cnt_r;
    reg       adc_en_d_r;

    wire sel_hit_slp;
    wire sel_hit_mcu;
    wire wr_slp;
    wire wr_mcu;
    wire vec_open;
    wire bod_open;
    wire scan_open;
    wire scan_commit;
    wire bod_active;
    wire deep_mode;
    wire io_adc_stopped;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function hit;
        input [7:0] a;
        input       io;
        input [7:0] base;
        begin
            hit = io ? (a == (base - `IO_ADDR_OFFSET)) : (a == base);
        end
    endfunction

    assign sel_hit_slp = hit(addr, io_space, `SLP_CTRL_ADDR);
    assign sel_hit_mcu = hit(addr, io_space, `MCU_CTRL_ADDR);
    assign wr_slp      = wr_en & sel_hit_slp;
    assign wr_mcu      = wr_en & sel_hit_mcu;
    // A mismatched write restarts the pair with a fresh window
    assign scan_commit = wr_mcu & scan_pend_r & scan_open &
                         (wdata[`SCAN_DIS_BIT] == scan_val_r);

    // ----------------------------------------------------------------
    // Unlock windows
    // ----------------------------------------------------------------
    // Vector unlock: armed by a write with unlock one, closed early by
    // the select write so a second change needs a fresh sequence
    unlock_timer #(
        .WINDOW (`UNLOCK_CYCLES)
    ) u_vec_win (
        .clk    (clk),
        .nrst   (nrst),
        .start  (wr_mcu & wdata[`VEC_UNLOCK_BIT]),
        .cancel (wr_mcu & vec_open & ~wdata[`VEC_UNLOCK_BIT]),
        .open   (vec_open)
    );

    unlock_timer #(
        .WINDOW (`UNLOCK_CYCLES)
    ) u_bod_win (
        .clk    (clk),
        .nrst   (nrst),
        .start  (wr_mcu & wdata[`BOD_OFF_BIT] & wdata[`BOD_UNLOCK_BIT]),
        .cancel (wr_mcu & bod_open & ~wdata[`BOD_UNLOCK_BIT]),
        .open   (bod_open)
    );

    unlock_timer #(
        .WINDOW (`UNLOCK_CYCLES)
    ) u_scan_win (
        .clk    (clk),
        .nrst   (nrst),
        .start  (wr_mcu & ~scan_commit),
        .cancel (scan_commit),
        .open   (scan_open)
    );

    // ----------------------------------------------------------------
    // Sleep mode control register
    // ----------------------------------------------------------------
    always @* begin
        slp_nxt = slp_r;
        if (wr_slp) begin
            slp_nxt = wdata & `SLP_CTRL_MASK;
        end
    end

    assign sleep_mode = slp_r[`SLP_SEL_MSB:`SLP_SEL_LSB];

    // ----------------------------------------------------------------
    // MCU control register
    // ----------------------------------------------------------------
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            slp_r         <= `SLP_CTRL_RESET;
            scan_dis_r    <= 1'b0;
            pullup_kill_r <= 1'b0;
            vec_sel_r     <= 1'b0;
            bod_unlock_r  <= 1'b0;
            scan_pend_r   <= 1'b0;
            scan_val_r    <= 1'b0;
            bod_off_r     <= 1'b0;
            bod_age_r     <= 3'h0;
            blk_tail_r    <= 1'b0;
        end else begin
            slp_r <= slp_nxt;
            // Two equal writes in the window commit the scan bit
            if (wr_mcu) begin
                if (scan_commit) begin
                    scan_dis_r  <= scan_val_r;
                    scan_pend_r <= 1'b0;
                end else begin
                    scan_pend_r <= 1'b1;
                    scan_val_r  <= wdata[`SCAN_DIS_BIT];
                end
            end else if (!scan_open) begin
                scan_pend_r <= 1'b0;
            end
            if (wr_mcu) begin
                pullup_kill_r <= wdata[`PULLUP_KILL_BIT];
            end
            // Select write only honoured inside the unlock window
            if (wr_mcu & vec_open & ~wdata[`VEC_UNLOCK_BIT]) begin
                vec_sel_r <= wdata[`VEC_SEL_BIT];
            end
            bod_unlock_r <= (wr_mcu & wdata[`BOD_UNLOCK_BIT]) |
                            (bod_open & ~wr_mcu);
            // Set sequence: both bits, then off with unlock cleared
            if (wr_mcu & bod_open & wdata[`BOD_OFF_BIT] &
                ~wdata[`BOD_UNLOCK_BIT]) begin
                bod_age_r <= 3'h1;
                bod_off_r <= 1'b1;
            end else if (bod_age_r != 3'h0) begin
                if (bod_age_r == (`BOD_DELAY_CYCLES + `BOD_HOLD_CYCLES)) begin
                    bod_age_r <= 3'h0;
                    bod_off_r <= 1'b0;
                end else begin
                    bod_age_r <= bod_age_r + 3'h1;
                end
            end
            // Keep blocking through the instruction after the select write
            if (wr_mcu & vec_open & ~wdata[`VEC_UNLOCK_BIT]) begin
                blk_tail_r <= 1'b1;
            end else if (instr_done) begin
                blk_tail_r <= 1'b0;
            end
        end
    end

    // Active once the set has aged past the delay
    assign bod_active = bod_off_r & (bod_age_r > `BOD_DELAY_CYCLES);

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always @* begin
        rdata = 8'h00;
        if (rd_en & sel_hit_slp) begin
            rdata = slp_r;
        end else if (rd_en & sel_hit_mcu) begin
            rdata[`SCAN_DIS_BIT]    = scan_dis_r;
            rdata[`BOD_OFF_BIT]     = bod_off_r;
            rdata[`BOD_UNLOCK_BIT]  = bod_unlock_r;
            rdata[`PULLUP_KILL_BIT] = pullup_kill_r;
            rdata[`VEC_SEL_BIT]     = vec_sel_r;
            rdata[`VEC_UNLOCK_BIT]  = vec_open;
        end
    end

    // ----------------------------------------------------------------
    // Static control outputs
    // ----------------------------------------------------------------
    assign scan_port_enable    = scan_fuse_enable & ~scan_dis_r;
    assign pullup_kill         = pullup_kill_r;
    assign vector_table_select = vec_sel_r;

    // Only gates delivery; the global enable flag lives elsewhere and
    // is never written from here
    assign irq_block = vec_open | blk_tail_r |
        (vec_sel_r & app_boot_lock_bit & ~in_boot_section) |
        (~vec_sel_r & boot_boot_lock_bit & in_boot_section);

    // ----------------------------------------------------------------
    // Sleep sequencing
    // ----------------------------------------------------------------
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (sleep_instr & slp_r[`SLP_ALLOW_BIT]) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_event) begin
                    state_nxt = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (wake_cnt_r == 3'h0) begin
                    state_nxt = ST_RUN;
                end
            end
            default: state_nxt = ST_RUN;
        endcase
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r      <= ST_RUN;
            sleeping     <= 1'b0;
            bod_sw_off_r <= 1'b0;
            wake_cnt_r   <= 3'h0;
            wake_ready   <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            sleeping   <= (state_nxt == ST_SLEEP);
            wake_ready <= (state_r == ST_WAKE) & (wake_cnt_r == 3'h0);
            if ((state_r == ST_RUN) & (state_nxt == ST_SLEEP)) begin
                bod_sw_off_r <= bod_active;
            end else if (state_nxt != ST_SLEEP) begin
                bod_sw_off_r <= 1'b0;
            end
            if ((state_r == ST_SLEEP) & wake_event) begin
                // Standby keeps the oscillator, so wake is short
                wake_cnt_r <= (sleep_mode[2:1] == 2'b11) ?
                    (`STBY_WAKE_CYCLES - 3'h1) : 3'h0;
            end else if (wake_cnt_r != 3'h0) begin
                wake_cnt_r <= wake_cnt_r - 3'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Power steering during sleep
    // ----------------------------------------------------------------
    assign deep_mode = sleeping & (sleep_mode != `MODE_IDLE) &
                       (sleep_mode != `MODE_ADC_NR);
    // Only idle keeps the I/O clock; only idle and ADC NR keep ADC clock
    assign io_adc_stopped = deep_mode;

    assign brownout_enable   = brownout_fuse_en & ~bod_sw_off_r;
    assign watchdog_keep     = watchdog_en;
    assign adc_keep_on       = adc_en;
    // Comparator always stops in deep sleep; its reference may not
    assign comparator_enable = comparator_en & ~deep_mode;
    assign vref_enable = brownout_enable | adc_en |
        (comparator_en & (~deep_mode | comparator_uses_ref));
    assign input_buffer_enable = ~io_adc_stopped |
                                 wake_pin_needed;
    // Debug system is dead once the scan port is disabled
    assign main_clock_keep = sleeping & debug_fuse_enable &
                             ~scan_dis_r;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            adc_en_d_r        <= 1'b0;
            adc_extended_conv <= 1'b0;
        end else begin
            adc_en_d_r <= adc_en;
            if (adc_en & ~adc_en_d_r) begin
                adc_extended_conv <= 1'b1;
            end else if (~adc_en) begin
                adc_extended_conv <= 1'b0;
            end
        end
    end

endmodule

//--- sleep_ctrl_props.sv
// Purpose: Port-level checks for the sleep and MCU control bank
// Assumes: One clock, async active-low reset
// Notes:   Reads are combinational, so read checks need no delay
`timescale 1ns/1ps

module sleep_ctrl_props (
    input wire       clk,
    input wire       nrst,
    input wire [7:0] addr,
    input wire       io_space,
    input wire       wr_en,
    input wire       rd_en,
    input wire [7:0] rdata,
    input wire       sleep_instr,
    input wire       wake_event,
    input wire       scan_fuse_enable,
    input wire       debug_fuse_enable,
    input wire       app_boot_lock_bit,
    input wire       boot_boot_lock_bit,
    input wire       watchdog_en,
    input wire       adc_en,
    input wire       comparator_en,
    input wire       comparator_uses_ref,
    input wire [2:0] sleep_mode,
    input wire       sleeping,
    input wire       scan_port_enable,
    input wire       pullup_kill,
    input wire       vector_table_select,
    input wire       irq_block,
    input wire       adc_keep_on,
    input wire       comparator_enable,
    input wire       vref_enable,
    input wire       main_clock_keep,
    input wire       watchdog_keep,
    input wire       wake_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_RD_IDLE: assert property (!rd_en |-> rdata == 8'h00)
        else $error("rdata not zero without read");
    AST_SLP_RD: assert property (rd_en && !io_space && addr == 8'h53
        |-> rdata[7:4] == 4'h0 && rdata[3:1] == sleep_mode)
        else $error("sleep register read mismatch");
    AST_IO_RD: assert property (rd_en && io_space && addr == 8'h35
        |-> rdata[3:2] == 2'b00 && rdata[1] == vector_table_select
            && rdata[4] == pullup_kill)
        else $error("port-space control read mismatch");
    AST_SCAN: assert property (scan_port_enable |-> scan_fuse_enable)
        else $error("scan port enabled without fuse");
    AST_SLEEP: assert property ($rose(sleeping) |-> $past(sleep_instr))
        else $error("sleep entered without sleep instruction");
    AST_VEC: assert property ($changed(vector_table_select)
        |-> $past(wr_en) && $past(irq_block))
        else $error("vector select changed outside window");
    AST_IRQ_RISE: assert property ($rose(irq_block)
        && !app_boot_lock_bit && !boot_boot_lock_bit |-> $past(wr_en))
        else $error("interrupt block raised without write");
    AST_KEEP: assert property ((watchdog_en |-> watchdog_keep)
        and (adc_en |-> adc_keep_on))
        else $error("enabled module dropped");
    AST_VREF: assert property (adc_en
        || (comparator_en && comparator_uses_ref) |-> vref_enable)
        else $error("reference off while needed");
    AST_COMP: assert property (sleeping && sleep_mode[1]
        |-> !comparator_enable)
        else $error("comparator on in deep sleep");
    AST_WAKE: assert property (sleeping && sleep_mode[2] && wake_event
        |-> ##[1:8] wake_ready)
        else $error("standby wake too slow");
    AST_DBG: assert property (sleeping && debug_fuse_enable
        && scan_port_enable |-> main_clock_keep)
        else $error("main clock stopped with debug on");
endmodule

bind sleep_and_mcu_control_regs sleep_ctrl_props i_sleep_ctrl_props (
    .clk(clk), .nrst(nrst), .addr(addr), .io_space(io_space),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .sleep_instr(sleep_instr), .wake_event(wake_event),
    .scan_fuse_enable(scan_fuse_enable),
    .debug_fuse_enable(debug_fuse_enable),
    .app_boot_lock_bit(app_boot_lock_bit),
    .boot_boot_lock_bit(boot_boot_lock_bit), .watchdog_en(watchdog_en),
    .adc_en(adc_en), .comparator_en(comparator_en),
    .comparator_uses_ref(comparator_uses_ref), .sleep_mode(sleep_mode),
    .sleeping(sleeping), .scan_port_enable(scan_port_enable),
    .pullup_kill(pullup_kill), .vector_table_select(vector_table_select),
    .irq_block(irq_block), .adc_keep_on(adc_keep_on),
    .comparator_enable(comparator_enable), .vref_enable(vref_enable),
    .main_clock_keep(main_clock_keep), .watchdog_keep(watchdog_keep),
    .wake_ready(wake_ready));

//--- tb.sv
// Purpose: Directed register-port bench for the sleep and MCU bank
// Assumes: Inputs change at falling edges, tasks start on one
// Notes:   Writes leave the strobe high so pairs can run back to back
`timescale 1ns/1ps
`include "sleep_ctrl_consts.vh"

module tb;
    logic       clk = 1'b0, nrst = 1'b0, io_space = 1'b0, wr_en = 1'b0;
    logic       rd_en = 1'b0, sleep_instr = 1'b0, instr_done = 1'b0;
    logic       wake_event = 1'b0, in_boot_section = 1'b0;
    logic       scan_fuse_enable = 1'b1, debug_fuse_enable = 1'b0;
    logic       app_boot_lock_bit = 1'b0, boot_boot_lock_bit = 1'b0;
    logic       brownout_fuse_en = 1'b0, watchdog_en = 1'b0, adc_en = 1'b0;
    logic       comparator_en = 1'b0, comparator_uses_ref = 1'b0;
    logic       wake_pin_needed = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00;
    wire  [7:0] rdata;
    wire  [2:0] sleep_mode;
    wire        sleeping, scan_port_enable, pullup_kill;
    wire        vector_table_select, irq_block, brownout_enable;
    wire        adc_keep_on, adc_extended_conv, comparator_enable;
    wire        vref_enable, input_buffer_enable, main_clock_keep;
    wire        watchdog_keep, wake_ready;
    int         num_errors = 0, checks = 0, n;

    always #20 clk = ~clk;

    sleep_and_mcu_control_regs i_sleep_and_mcu_control_regs (.*);

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Leaves wr_en high; idle() ends a burst
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a; wdata = d; io_space = 1'b0; wr_en = 1'b1; rd_en = 1'b0;
        @(negedge clk);
    endtask

    task automatic idle();
        wr_en = 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic io,
                      input logic [7:0] mask, input logic [7:0] exp);
        addr = a; io_space = io; rd_en = 1'b1;
        #5 chk("rdata", exp, rdata & mask);
        @(negedge clk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Bound well above the hundred or so cycles the sequence needs
    initial begin
        #80000;
        num_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        // ------------------------------------------------------------
        // Reset values, aliases, unmapped place
        // ------------------------------------------------------------
        rd(`SLP_CTRL_ADDR, 1'b0, 8'hFF, 8'h00);
        rd(`MCU_CTRL_ADDR, 1'b0, 8'hFF, 8'h00);
        wr(`SLP_CTRL_ADDR, 8'hFF); idle();
        rd(8'h33, 1'b1, 8'hFF, 8'h0F);
        rd(8'h54, 1'b0, 8'hFF, 8'h00);
        for (n = 0; n < 8; n++) begin
            wr(`SLP_CTRL_ADDR, 8'(n << 1)); idle();
            chk("sleep_mode", 8'(n), {5'h00, sleep_mode});
        end
        // ------------------------------------------------------------
        // Vector select sequence, stray write, timeout
        // ------------------------------------------------------------
        wr(`MCU_CTRL_ADDR, 8'h01);
        chk("irq_block", 8'h01, {7'h00, irq_block});
        wr(`MCU_CTRL_ADDR, 8'h02); idle();
        rd(`MCU_CTRL_ADDR, 1'b0, 8'hFF, 8'h02);
        chk("irq_block held", 8'h01, {7'h00, irq_block});
        instr_done = 1'b1; @(negedge clk); instr_done = 1'b0;
        chk("irq_block end", 8'h00, {7'h00, irq_block});
        wr(`MCU_CTRL_ADDR, 8'h00); idle();
        chk("vec stray", 8'h01, {7'h00, vector_table_select});
        wr(`MCU_CTRL_ADDR, 8'h01); idle();
        repeat (5) @(negedge clk);
        chk("irq_block timeout", 8'h00, {7'h00, irq_block});
        rd(`MCU_CTRL_ADDR, 1'b0, 8'h01, 8'h00);
        wr(`MCU_CTRL_ADDR, 8'h00); idle();
        chk("vec late", 8'h01, {7'h00, vector_table_select});
        app_boot_lock_bit = 1'b1; @(negedge clk);
        chk("app lock", 8'h01, {7'h00, irq_block});
        in_boot_section = 1'b1; @(negedge clk);
        chk("boot code", 8'h00, {7'h00, irq_block});
        app_boot_lock_bit = 1'b0; in_boot_section = 1'b0;
        // ------------------------------------------------------------
        // Scan disable pair, pull-up kill, brown-out sequence
        // ------------------------------------------------------------
        wr(`MCU_CTRL_ADDR, 8'h80); idle();
        repeat (5) @(negedge clk);
        rd(`MCU_CTRL_ADDR, 1'b0, 8'h80, 8'h00);
        chk("scan en", 8'h01, {7'h00, scan_port_enable});
        wr(`MCU_CTRL_ADDR, 8'h80); wr(`MCU_CTRL_ADDR, 8'h90); idle();
        rd(`MCU_CTRL_ADDR, 1'b0, 8'h92, 8'h92);
        chk("scan dis", 8'h00, {7'h00, scan_port_enable});
        chk("pullup", 8'h01, {7'h00, pullup_kill});
        rd(8'h35, 1'b1, 8'h92, 8'h92);
        wr(`MCU_CTRL_ADDR, 8'hE0); wr(`MCU_CTRL_ADDR, 8'hC0); idle();
        rd(`MCU_CTRL_ADDR, 1'b0, 8'h60, 8'h40);
        repeat (8) @(negedge clk);
        rd(`MCU_CTRL_ADDR, 1'b0, 8'h40, 8'h00);
        // ------------------------------------------------------------
        // Sleep gating, standby wake, power-down steering
        // ------------------------------------------------------------
        wr(`SLP_CTRL_ADDR, 8'h0C); idle();
        sleep_instr = 1'b1; @(negedge clk); sleep_instr = 1'b0;
        chk("no sleep", 8'h00, {7'h00, sleeping});
        wr(`SLP_CTRL_ADDR, 8'h0D); idle();
        sleep_instr = 1'b1; @(negedge clk); sleep_instr = 1'b0;
        chk("sleeping", 8'h01, {7'h00, sleeping});
        wake_event = 1'b1; @(negedge clk); wake_event = 1'b0;
        n = 0;
        while (wake_ready !== 1'b1 && n < 12) begin
            @(negedge clk); n++;
        end
        chk("wake span", 8'h01, {7'h00, n < 7});
        wr(`SLP_CTRL_ADDR, 8'h0C); idle();
        {adc_en, watchdog_en, brownout_fuse_en} = 3'b111;
        {comparator_en, comparator_uses_ref, debug_fuse_enable} = 3'b111;
        wr(`SLP_CTRL_ADDR, 8'h05); idle();
        sleep_instr = 1'b1; @(negedge clk); sleep_instr = 1'b0;
        chk("adc keep", 8'h01, {7'h00, adc_keep_on});
        chk("adc ext", 8'h01, {7'h00, adc_extended_conv});
        chk("clk keep off", 8'h00, {7'h00, main_clock_keep});
        chk("comp off", 8'h00, {7'h00, comparator_enable});
        chk("vref", 8'h01, {7'h00, vref_enable});
        chk("bod on", 8'h01, {7'h00, brownout_enable});
        chk("wdt keep", 8'h01, {7'h00, watchdog_keep});
        chk("inbuf off", 8'h00, {7'h00, input_buffer_enable});
        wake_pin_needed = 1'b1; @(negedge clk);
        chk("inbuf wake", 8'h01, {7'h00, input_buffer_enable});
        wake_event = 1'b1; @(negedge clk); wake_event = 1'b0;
        n = 0;
        while (sleeping !== 1'b0 && n < 200) begin
            @(negedge clk); n++;
        end
        chk("awake", 8'h00, {7'h00, sleeping});
        // Pair of bit 7 zero writes also re-enables the scan port
        wr(`MCU_CTRL_ADDR, 8'h60); wr(`MCU_CTRL_ADDR, 8'h40); idle();
        repeat (2) @(negedge clk);
        sleep_instr = 1'b1; @(negedge clk); sleep_instr = 1'b0;
        chk("bod off", 8'h00, {7'h00, brownout_enable});
        chk("clk keep", 8'h01, {7'h00, main_clock_keep});
        wake_event = 1'b1; @(negedge clk); wake_event = 1'b0;
        chk("bod back", 8'h01, {7'h00, brownout_enable});
        tally_and_finish();
    end
endmodule
